// file: pkg/eia_pkg.sv
// Package for the emergency stop input assignment block
package eia_pkg;
  localparam int FUNC_W = 7;
  localparam int POL_W = 2;
  localparam int NUM_INPUTS = 5;
  localparam logic [FUNC_W-1:0] FUNC_FAULT_CLEAR = 7'h12;
  localparam logic [FUNC_W-1:0] FUNC_EMERGENCY_HALT = 7'h40;
  localparam logic [FUNC_W-1:0] FUNC_JOG = 7'h06;
  localparam logic [FUNC_W-1:0] FUNC_NONE = 7'h7F;
  localparam logic [POL_W-1:0] POL_NO = 2'h0;
  localparam logic [POL_W-1:0] POL_NC = 2'h1;
  localparam int IDX_ONE = 0;
  localparam int IDX_THREE = 2;

  // One user write request to one input slot
  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic [FUNC_W-1:0] func;
    logic [POL_W-1:0] pol;
  } eia_write_s;

  // Setting of one input slot
  typedef struct packed {
    logic [FUNC_W-1:0] func;
    logic [POL_W-1:0] pol;
  } eia_slot_s;

  typedef enum logic [1:0] {EIA_OFF, EIA_ON, EIA_RELEASED} eia_mode_e;
endpackage : eia_pkg

// file: hdl/eia_trip.sv
// Emergency trip latch driven by the halt and fault-clear inputs
`timescale 1ns/1ns
module eia_trip (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic armed,
  input wire logic halt_contact,
  input wire logic clear_contact,
  input wire logic panel_clear,
  output logic trip,
  output logic switching_enable
);
  logic trip_reg;
  logic trip_next;

  // Missing halt contact trips; only the input one clear releases
  always_comb begin
    trip_next = trip_reg;
    if (armed && !halt_contact) begin
      trip_next = 1'b1;
    end else if (clear_contact) begin
      trip_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trip_reg <= 1'b0;
    end else if (clk_en) begin
      trip_reg <= trip_next;
    end
  end

  // Gating is combinational so the output stops in the same cycle
  assign trip = trip_reg;
  assign switching_enable = !(trip_reg || (armed && !halt_contact));

  a_panel_no_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && trip_reg && !clear_contact && panel_clear && !(armed && !halt_contact)) |=> trip_reg)
    else $error("panel cleared trip");
  a_halt_trips: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && armed && !halt_contact) |=> trip_reg)
    else $error("halt missed");
  c_trip_clear: cover property (@(posedge clk) disable iff (sys_rst) trip_reg ##1 !trip_reg);
endmodule : eia_trip

// file: hdl/eia_assign.sv
// Input function assignment governed by the emergency stop enable switch
`timescale 1ns/1ns
module eia_assign #(
  parameter int NUM = eia_pkg::NUM_INPUTS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic estop_enable_switch,
  input wire eia_pkg::eia_write_s panel_write,
  input wire eia_pkg::eia_write_s copy_write,
  input wire logic [NUM-1:0] contact_in,
  input wire logic panel_clear,
  output eia_pkg::eia_slot_s [NUM-1:0] slots,
  output logic write_reject,
  output logic copy_error,
  output logic emergency_trip_state,
  output logic switching_enable
);
  // Slot index is three bits wide and slots one and three must exist
  if (NUM < 3 || NUM > 8) begin : g_num_check
    $error("NUM must be 3..8");
  end

  eia_pkg::eia_slot_s [NUM-1:0] slot_reg;
  eia_pkg::eia_slot_s [NUM-1:0] slot_next;
  eia_pkg::eia_mode_e mode_reg;
  eia_pkg::eia_mode_e mode_next;
  logic sw_reg;
  logic reject_reg;
  logic reject_next;
  logic cerr_reg;
  logic cerr_next;
  logic [NUM-1:0] active;
  logic halt_contact;
  logic clear_contact;

  // Locked slot check shared by panel and copy paths
  function automatic logic locked(input logic [2:0] idx, input logic on);
    locked = on && (idx == 3'(eia_pkg::IDX_ONE) || idx == 3'(eia_pkg::IDX_THREE));
  endfunction : locked

  // Apply polarity implied by a function code
  function automatic eia_pkg::eia_slot_s fix_pol(input eia_pkg::eia_slot_s s, input logic is_three);
    fix_pol = s;
    if (s.func == eia_pkg::FUNC_FAULT_CLEAR) fix_pol.pol = eia_pkg::POL_NO;
    if (is_three && s.func == eia_pkg::FUNC_EMERGENCY_HALT) fix_pol.pol = eia_pkg::POL_NC;
  endfunction : fix_pol

  // Mode tracking and slot update
  always_comb begin
    slot_next = slot_reg;
    mode_next = mode_reg;
    reject_next = 1'b0;
    cerr_next = 1'b0;
    case (mode_reg)
      eia_pkg::EIA_OFF, eia_pkg::EIA_RELEASED: begin
        if (estop_enable_switch && !sw_reg) begin
          mode_next = eia_pkg::EIA_ON;
          for (int i = 0; i < NUM; i++) begin
            if (i != eia_pkg::IDX_ONE && i != eia_pkg::IDX_THREE &&
                slot_reg[i].func == eia_pkg::FUNC_FAULT_CLEAR) begin
              slot_next[i].func = eia_pkg::FUNC_NONE;
            end
          end
          slot_next[eia_pkg::IDX_ONE].func = eia_pkg::FUNC_FAULT_CLEAR;
          slot_next[eia_pkg::IDX_THREE].func = eia_pkg::FUNC_EMERGENCY_HALT;
        end
      end
      eia_pkg::EIA_ON: begin
        if (!estop_enable_switch) begin
          mode_next = eia_pkg::EIA_RELEASED;
          // Input one and polarities kept; no restore of old settings
          slot_next[eia_pkg::IDX_THREE].func = eia_pkg::FUNC_NONE;
        end
      end
      default: mode_next = eia_pkg::EIA_OFF;
    endcase
    // User writes only while no switch transition is happening
    if (mode_next == mode_reg) begin
      if (panel_write.valid) begin
        if (locked(panel_write.index, mode_reg == eia_pkg::EIA_ON) ||
            (panel_write.index == 3'(eia_pkg::IDX_THREE) &&
             panel_write.func == eia_pkg::FUNC_EMERGENCY_HALT) ||
            int'(panel_write.index) >= NUM) begin
          reject_next = 1'b1;
        end else begin
          slot_next[panel_write.index].func = panel_write.func;
          slot_next[panel_write.index].pol = panel_write.pol;
        end
      end else if (copy_write.valid && int'(copy_write.index) < NUM) begin
        if (locked(copy_write.index, mode_reg == eia_pkg::EIA_ON)) begin
          cerr_next = 1'b1;
        end else begin
          slot_next[copy_write.index].func = copy_write.func;
          slot_next[copy_write.index].pol = copy_write.pol;
        end
      end
    end
    for (int i = 0; i < NUM; i++) begin
      slot_next[i] = fix_pol(slot_next[i], i == eia_pkg::IDX_THREE);
    end
  end

  // Reset loads the factory assignment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM; i++) begin
        slot_reg[i] <= '{func: eia_pkg::FUNC_NONE, pol: eia_pkg::POL_NO};
      end
      slot_reg[eia_pkg::IDX_ONE] <= '{func: eia_pkg::FUNC_FAULT_CLEAR, pol: eia_pkg::POL_NO};
      slot_reg[eia_pkg::IDX_THREE] <= '{func: eia_pkg::FUNC_JOG, pol: eia_pkg::POL_NO};
      mode_reg <= eia_pkg::EIA_OFF;
      sw_reg <= 1'b0;
      reject_reg <= 1'b0;
      cerr_reg <= 1'b0;
    end else if (clk_en) begin
      slot_reg <= slot_next;
      mode_reg <= mode_next;
      sw_reg <= estop_enable_switch;
      reject_reg <= reject_next;
      cerr_reg <= cerr_next;
    end
  end

  // Contact levels after polarity; halt contact is taken raw, before polarity
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      active[i] = contact_in[i] ^ (slot_reg[i].pol == eia_pkg::POL_NC);
    end
    halt_contact = contact_in[eia_pkg::IDX_THREE];
    clear_contact = active[eia_pkg::IDX_ONE] && slot_reg[eia_pkg::IDX_ONE].func == eia_pkg::FUNC_FAULT_CLEAR;
  end

  eia_trip u_trip (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .armed(mode_reg == eia_pkg::EIA_ON),
    .halt_contact(halt_contact),
    .clear_contact(clear_contact),
    .panel_clear(panel_clear),
    .trip(emergency_trip_state),
    .switching_enable(switching_enable)
  );

  assign slots = slot_reg;
  assign write_reject = reject_reg;
  assign copy_error = cerr_reg;

  a_on_assigns: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && estop_enable_switch && !sw_reg && mode_reg != eia_pkg::EIA_ON) |=>
    (slot_reg[eia_pkg::IDX_ONE].func == eia_pkg::FUNC_FAULT_CLEAR &&
     slot_reg[eia_pkg::IDX_THREE].func == eia_pkg::FUNC_EMERGENCY_HALT))
    else $error("switch on assignment missing");
  a_clear_pol_no: assert property (@(posedge clk) disable iff (sys_rst)
    slot_reg[eia_pkg::IDX_ONE].func == eia_pkg::FUNC_FAULT_CLEAR |->
    slot_reg[eia_pkg::IDX_ONE].pol == eia_pkg::POL_NO)
    else $error("fault clear polarity wrong");
  a_halt_pol_nc: assert property (@(posedge clk) disable iff (sys_rst)
    slot_reg[eia_pkg::IDX_THREE].func == eia_pkg::FUNC_EMERGENCY_HALT |->
    slot_reg[eia_pkg::IDX_THREE].pol == eia_pkg::POL_NC)
    else $error("halt polarity wrong");
  a_dup_cleared: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && estop_enable_switch && !sw_reg && mode_reg != eia_pkg::EIA_ON &&
     slot_reg[1].func == eia_pkg::FUNC_FAULT_CLEAR) |=> slot_reg[1].func == eia_pkg::FUNC_NONE)
    else $error("duplicate fault clear kept");
  a_off_release: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_reg == eia_pkg::EIA_ON && !estop_enable_switch) |=>
    (slot_reg[eia_pkg::IDX_THREE].func == eia_pkg::FUNC_NONE &&
     slot_reg[eia_pkg::IDX_THREE].pol == eia_pkg::POL_NC &&
     slot_reg[eia_pkg::IDX_ONE].func == eia_pkg::FUNC_FAULT_CLEAR))
    else $error("switch off release wrong");
  a_panel_halt_rej: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && panel_write.valid && panel_write.index == 3'(eia_pkg::IDX_THREE) &&
     panel_write.func == eia_pkg::FUNC_EMERGENCY_HALT && mode_reg != eia_pkg::EIA_ON &&
     !(estop_enable_switch && !sw_reg)) |=>
    slot_reg[eia_pkg::IDX_THREE].func != eia_pkg::FUNC_EMERGENCY_HALT)
    else $error("panel halt accepted");
  a_lock_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_reg == eia_pkg::EIA_ON && estop_enable_switch) |=>
    $stable(slot_reg[eia_pkg::IDX_ONE]) && $stable(slot_reg[eia_pkg::IDX_THREE]))
    else $error("locked slot changed");
  a_copy_skip: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_reg == eia_pkg::EIA_ON && estop_enable_switch && !panel_write.valid &&
     copy_write.valid && locked(copy_write.index, 1'b1)) |=> copy_error)
    else $error("copy skip not flagged");
  c_switch_on: cover property (@(posedge clk) mode_reg == eia_pkg::EIA_ON);
  c_released: cover property (@(posedge clk) mode_reg == eia_pkg::EIA_RELEASED);
  c_rejected: cover property (@(posedge clk) write_reject);
  c_copy_err: cover property (@(posedge clk) copy_error);
endmodule : eia_assign

// file: dv/eia_contact_model.sv
// Contact wiring and operator panel model for the assignment block
`timescale 1ns/1ns
module eia_contact_model #(
  parameter int NUM = 5
) (
  input wire logic halt_pressed,
  input wire logic clear_pressed,
  output logic [NUM-1:0] contact_in
);
  // Halt is wired normally closed, so a press or a broken wire reads open
  always_comb begin
    contact_in = '0;
    contact_in[eia_pkg::IDX_THREE] = ~halt_pressed;
    contact_in[eia_pkg::IDX_ONE] = clear_pressed; // Normally open push button
  end
endmodule : eia_contact_model

// file: dv/estop_input_assignment_test.sv
// Self-checking bench for the emergency stop input assignment block
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end
module estop_input_assignment_test;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic clk_en = 1'h1;
  logic estop_enable_switch = 1'h0;
  eia_pkg::eia_write_s panel_write = '0;
  eia_pkg::eia_write_s copy_write = '0;
  logic halt_pressed = 1'h0;
  logic clear_pressed = 1'h0;
  logic panel_clear = 1'h0;
  logic [4:0] contact_in;
  eia_pkg::eia_slot_s [4:0] slots;
  logic write_reject;
  logic copy_error;
  logic trip;
  logic switching_enable;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  eia_assign #(.NUM(5)) uut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .estop_enable_switch(estop_enable_switch),
    .panel_write(panel_write), .copy_write(copy_write), .contact_in(contact_in),
    .panel_clear(panel_clear), .slots(slots), .write_reject(write_reject), .copy_error(copy_error),
    .emergency_trip_state(trip), .switching_enable(switching_enable)
  );

  eia_contact_model #(.NUM(5)) model (
    .halt_pressed(halt_pressed), .clear_pressed(clear_pressed), .contact_in(contact_in)
  );

  // Free running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Hang guard, far beyond the few dozen cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Inputs move 1 ns after the edge so sampling never races
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  // One-cycle request; returns just after the taking edge, where flags stand
  task automatic wr(input logic cp, input logic [2:0] idx, input logic [6:0] f, input logic [1:0] p);
    step();
    if (cp) begin
      copy_write = '{1'h1, idx, f, p};
    end else begin
      panel_write = '{1'h1, idx, f, p};
    end
    step();
    panel_write.valid = 1'h0;
    copy_write.valid = 1'h0;
  endtask : wr

  task automatic t_switch_on();
    wr(1'h0, 3'h1, 7'h12, 2'h1);
    `CHK(slots[1], {7'h12, 2'h0})
    `CHK(slots[2], {7'h06, 2'h0})
    estop_enable_switch = 1'h1;
    step();
    step();
    `CHK(slots[0], {7'h12, 2'h0})
    `CHK(slots[2], {7'h40, 2'h1})
    `CHK(slots[1].func, 7'h7F)
    $display("test switch_on done");
  endtask : t_switch_on

  task automatic t_locked();
    wr(1'h0, 3'h0, 7'h06, 2'h0);
    `CHK(write_reject, 1'h1)
    `CHK(slots[0], {7'h12, 2'h0})
    wr(1'h1, 3'h2, 7'h06, 2'h0);
    `CHK(copy_error, 1'h1)
    wr(1'h1, 3'h3, 7'h06, 2'h1);
    `CHK(copy_error, 1'h0)
    `CHK(slots[3], {7'h06, 2'h1})
    `CHK(slots[2], {7'h40, 2'h1})
    $display("test locked done");
  endtask : t_locked

  // Trip must come from the halt contact alone and leave only by input one
  task automatic t_trip();
    halt_pressed = 1'h1;
    #1;
    `CHK(switching_enable, 1'h0)
    step();
    `CHK(trip, 1'h1)
    halt_pressed = 1'h0;
    panel_clear = 1'h1;
    step();
    step();
    `CHK(trip, 1'h1)
    panel_clear = 1'h0;
    clear_pressed = 1'h1;
    step();
    step();
    clear_pressed = 1'h0;
    `CHK(trip, 1'h0)
    `CHK(switching_enable, 1'h1)
    $display("test trip done");
  endtask : t_trip

  task automatic t_switch_off();
    estop_enable_switch = 1'h0;
    step();
    step();
    `CHK(slots[2], {7'h7F, 2'h1})
    `CHK(slots[0], {7'h12, 2'h0})
    `CHK(slots[1].func, 7'h7F)
    wr(1'h0, 3'h2, 7'h40, 2'h1);
    `CHK(write_reject, 1'h1)
    `CHK(slots[2], {7'h7F, 2'h1})
    wr(1'h0, 3'h0, 7'h06, 2'h0);
    `CHK(write_reject, 1'h0)
    `CHK(slots[0], {7'h06, 2'h0})
    // Frozen clock enable must not let a reassignment through
    clk_en = 1'h0;
    wr(1'h0, 3'h1, 7'h06, 2'h1);
    `CHK(slots[1].func, 7'h7F)
    `CHK(write_reject, 1'h0)
    clk_en = 1'h1;
    wr(1'h0, 3'h1, 7'h06, 2'h1);
    `CHK(slots[1], {7'h06, 2'h1})
    $display("test switch_off done");
  endtask : t_switch_off

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    t_switch_on();
    t_locked();
    t_trip();
    t_switch_off();
    print_verdict();
  end
endmodule : estop_input_assignment_test
